/* design/mcpg_pkg.sv */
// package: register map, field layout and constants of the mission counters and password gate
package mcpg_pkg;
  localparam logic [9:0] ADDR_TIMESTAMP  = 10'h219;
  localparam logic [9:0] ADDR_MISSION_CNT = 10'h220;
  localparam logic [9:0] ADDR_LIFE_CNT   = 10'h223;
  localparam logic [9:0] ADDR_VARIANT    = 10'h226;
  localparam logic [9:0] ADDR_PW_CTRL    = 10'h227;
  localparam logic [9:0] ADDR_DELAY      = 10'h216;
  localparam logic [9:0] ADDR_READ_PW    = 10'h228;
  localparam logic [9:0] ADDR_FULL_PW    = 10'h230;
  localparam int         TS_BYTES        = 6;
  localparam int         CNT_BYTES       = 3;
  localparam int         PW_BYTES        = 8;
  localparam logic [7:0] PW_ENABLE_VALUE = 8'haa;
  localparam logic [7:0] PW_CTRL_RESET   = 8'h00;
  localparam logic [7:0] VARIANT_DEFAULT = 8'h5a; // arbitrary code, not a real part's
  localparam int         PW_BITS         = 64;

  // command classes seen by the gate, password-protected and free
  typedef enum logic [2:0] {
    CMD_NONE      = 3'h0,
    CMD_READ_CRC  = 3'h1,
    CMD_COPY_SP   = 3'h2,
    CMD_CLEAR_MEM = 3'h3,
    CMD_START     = 3'h4,
    CMD_STOP      = 3'h5,
    CMD_FORCED    = 3'h6,
    CMD_SCRATCH   = 3'h7
  } mcpg_cmd_e;

  // gate states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PW   = 3'b010,
    ST_DONE = 3'b100
  } mcpg_state_e;

  // calendar time as six bcd bytes, seconds first
  typedef struct packed {
    logic [7:0] years;
    logic [7:0] months;
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } mcpg_time_s;
endpackage

/* design/mcpg_top.sv */
// module: mission bookkeeping counters, start delay and password gate of the logger
`timescale 1ns/1ps
module mcpg_top #(
  parameter logic [7:0] VARIANT = mcpg_pkg::VARIANT_DEFAULT
) (
  input  wire logic                SYS_CLK,
  input  wire logic                SYS_RST,
  // register access from the memory command path
  input  wire logic [9:0]          MEM_ADDR,
  input  wire logic                MEM_WR,
  input  wire logic [7:0]          MEM_WDATA,
  output logic      [7:0]          MEM_RDATA,
  // command and serial password bits
  input  wire logic                CMD_VALID,
  input  wire mcpg_pkg::mcpg_cmd_e CMD_CODE,
  input  wire logic                PW_BIT_VALID,
  input  wire logic                PW_BIT,
  input  wire logic                CMD_END,
  output logic                     CMD_GRANT,
  output logic                     CMD_DENY,
  // mission events from the sampling logic
  input  wire logic                MISSION_ACTIVE,
  input  wire logic                START_ON_TEMP_ALARM,
  input  wire logic                MINUTE_TICK,
  input  wire logic                MISSION_START,
  input  wire logic                SAMPLE_TAKEN,
  input  wire logic                FIRST_SAMPLE,
  input  wire logic                ALARM_TEST,
  input  wire mcpg_pkg::mcpg_time_s RTC_TIME,
  output logic                     DELAY_EXPIRED,
  output logic                     ALARM_FLAGS_CLR,
  output logic                     CHECK_ENABLED
);

  logic [47:0]                 ts_ff;
  logic [23:0]                 mission_cnt_ff;
  logic [23:0]                 life_cnt_ff;
  logic [23:0]                 delay_ff;
  logic [23:0]                 delay_left_ff;
  logic [7:0]                  pw_ctrl_ff;
  logic [63:0]                 read_pw_ff;
  logic [63:0]                 full_pw_ff;
  logic [63:0]                 rx_pw_ff;
  logic [6:0]                  rx_cnt_ff;
  mcpg_pkg::mcpg_cmd_e         cmd_ff;
  mcpg_pkg::mcpg_state_e       state_ff;
  logic                        full_ok_ff;
  logic                        check_on;
  logic                        pw_match;
  logic                        clear_exec;
  logic                        free_cmd;
  logic                        pw_wr_ok;

  // password length, and the count that a spoiled length parks the bit counter on
  localparam logic [6:0] PW_FULL_CNT  = 7'(mcpg_pkg::PW_BITS);
  localparam logic [6:0] PW_SPOIL_CNT = 7'(mcpg_pkg::PW_BITS + 1);

  // byte select of a little-endian field, used by the read mux for every readable multi-byte register
  function automatic logic [7:0] pick_byte(input logic [63:0] v, input logic [9:0] off);
    pick_byte = v[{off[2:0], 3'b000} +: 8];
  endfunction

  // commands that bypass the password phase; anything else except CMD_NONE waits for 64 bits
  function automatic logic is_free_cmd(input mcpg_pkg::mcpg_cmd_e c);
    is_free_cmd = (c == mcpg_pkg::CMD_FORCED) || (c == mcpg_pkg::CMD_SCRATCH);
  endfunction

  // address window test shared by the write decode and the read mux; lim is exclusive
  function automatic logic in_window(input logic [9:0] a, input logic [9:0] base,
                                     input logic [9:0] lim);
    in_window = (a >= base) && (a < lim);
  endfunction

  assign check_on   = (pw_ctrl_ff == mcpg_pkg::PW_ENABLE_VALUE);
  // read-crc accepts either password, the rest only full access
  assign pw_match   = (rx_pw_ff == full_pw_ff) ||
                      ((cmd_ff == mcpg_pkg::CMD_READ_CRC) && (rx_pw_ff == read_pw_ff));
  assign clear_exec = CMD_GRANT && (cmd_ff == mcpg_pkg::CMD_CLEAR_MEM);
  // free decode of the incoming code, taken only in the idle state
  assign free_cmd   = is_free_cmd(CMD_CODE);

  // password gate: collect 64 bits after the command code, then decide
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_ff  <= mcpg_pkg::ST_IDLE;
      cmd_ff    <= mcpg_pkg::CMD_NONE;
      rx_pw_ff  <= 64'h0;
      rx_cnt_ff <= 7'h00;
      CMD_GRANT <= 1'b0;
      CMD_DENY  <= 1'b0;
    end else begin
      CMD_GRANT <= 1'b0;
      CMD_DENY  <= 1'b0;
      case (state_ff)
        mcpg_pkg::ST_IDLE: begin
          if (CMD_VALID) begin
            cmd_ff    <= CMD_CODE;
            rx_cnt_ff <= 7'h00;
            if (free_cmd || CMD_CODE == mcpg_pkg::CMD_NONE) begin
              CMD_GRANT <= (CMD_CODE != mcpg_pkg::CMD_NONE);
              state_ff  <= mcpg_pkg::ST_DONE;
            end else begin
              state_ff <= mcpg_pkg::ST_PW;
            end
          end
        end
        mcpg_pkg::ST_PW: begin
          if (PW_BIT_VALID && rx_cnt_ff != PW_FULL_CNT) begin
            rx_pw_ff  <= {PW_BIT, rx_pw_ff[63:1]}; // bit 0 arrives first
            rx_cnt_ff <= rx_cnt_ff + 7'd1;
          end else if (PW_BIT_VALID || CMD_END) begin
            // a 65th bit or an early end spoils the length
            if (CMD_END && rx_cnt_ff == PW_FULL_CNT && (!check_on || pw_match)) begin
              CMD_GRANT <= 1'b1;
            end else begin
              CMD_DENY <= 1'b1;
            end
            rx_cnt_ff <= PW_SPOIL_CNT;
            state_ff  <= mcpg_pkg::ST_DONE;
          end
        end
        // one idle cycle after every answer before the next code is taken
        mcpg_pkg::ST_DONE: begin
          state_ff <= mcpg_pkg::ST_IDLE;
        end
        default: state_ff <= mcpg_pkg::ST_IDLE;
      endcase
    end
  end

  // full-access proof for password-area writes, held until the next command
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      full_ok_ff <= 1'b0;
    end else if (CMD_GRANT && cmd_ff == mcpg_pkg::CMD_COPY_SP) begin
      // a grant wins over a code that arrives while the gate is still busy
      full_ok_ff <= !check_on || (rx_pw_ff == full_pw_ff);
    end else if (CMD_VALID) begin
      full_ok_ff <= 1'b0;
    end
  end

  // password-area writes need a stopped mission and, with checking on, full access
  assign pw_wr_ok = MEM_WR && !MISSION_ACTIVE && (!check_on || full_ok_ff);

  // password control pattern; resets to a value that leaves checking off
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pw_ctrl_ff <= mcpg_pkg::PW_CTRL_RESET;
    end else if (pw_wr_ok && MEM_ADDR == mcpg_pkg::ADDR_PW_CTRL) begin
      pw_ctrl_ff <= MEM_WDATA;
    end
  end

  // password registers, write-only from the bus; each is decoded as its own aligned eight-byte block
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      read_pw_ff <= 64'h0;
      full_pw_ff <= 64'h0;
    end else if (pw_wr_ok) begin
      if (MEM_ADDR[9:3] == mcpg_pkg::ADDR_READ_PW[9:3]) begin
        read_pw_ff[{MEM_ADDR[2:0], 3'b000} +: 8] <= MEM_WDATA;
      end
      if (MEM_ADDR[9:3] == mcpg_pkg::ADDR_FULL_PW[9:3]) begin
        full_pw_ff[{MEM_ADDR[2:0], 3'b000} +: 8] <= MEM_WDATA;
      end
    end
  end

  // start delay setting, writable only between missions
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      delay_ff <= 24'h0;
    end else if (MEM_WR && !MISSION_ACTIVE) begin
      if (in_window(MEM_ADDR, mcpg_pkg::ADDR_DELAY, mcpg_pkg::ADDR_TIMESTAMP)) begin
        delay_ff[{MEM_ADDR[1:0] - 2'd2, 3'b000} +: 8] <= MEM_WDATA;
      end
    end
  end

  // minutes still to wait; loaded at mission start, one off per minute tick
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      delay_left_ff <= 24'h0;
    end else if (MISSION_START) begin
      delay_left_ff <= delay_ff;
    end else if (MISSION_ACTIVE && MINUTE_TICK && !DELAY_EXPIRED) begin
      delay_left_ff <= delay_left_ff - 24'h1;
    end
  end

  // expiry gates first sample or alarm test; a zero delay expires at once
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      DELAY_EXPIRED <= 1'b0;
    end else if (MISSION_START) begin
      DELAY_EXPIRED <= (delay_ff == 24'h0);
    end else if (!MISSION_ACTIVE) begin
      DELAY_EXPIRED <= 1'b0;
    end else if (MINUTE_TICK && !DELAY_EXPIRED) begin
      DELAY_EXPIRED <= (delay_left_ff == 24'h1);
    end
  end

  // timestamp captured at the first sample, cleared by clear memory
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ts_ff <= 48'h0;
    end else if (clear_exec) begin
      ts_ff <= 48'h0;
    end else if (FIRST_SAMPLE && SAMPLE_TAKEN && MISSION_ACTIVE) begin
      ts_ff <= RTC_TIME;
    end
  end

  // mission counter; one wake-up counts once however many channels it logs
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      mission_cnt_ff <= 24'h0;
    end else if (clear_exec) begin
      mission_cnt_ff <= 24'h0;
    end else if (SAMPLE_TAKEN && MISSION_ACTIVE &&
                 !(FIRST_SAMPLE && START_ON_TEMP_ALARM)) begin
      mission_cnt_ff <= mission_cnt_ff + 24'h1;
    end
  end

  // lifetime counter: no command clears it, only reset; it wraps at 24 bits
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      life_cnt_ff <= 24'h0;
    end else if (MISSION_ACTIVE && (SAMPLE_TAKEN || ALARM_TEST)) begin
      life_cnt_ff <= life_cnt_ff + 24'h1;
    end else if (!MISSION_ACTIVE && CMD_GRANT && cmd_ff == mcpg_pkg::CMD_FORCED) begin
      life_cnt_ff <= life_cnt_ff + 24'h1;
    end
  end

  // alarm flag clear pulse for the sampling logic, one cycle after the grant
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ALARM_FLAGS_CLR <= 1'b0;
    end else begin
      ALARM_FLAGS_CLR <= clear_exec;
    end
  end

  // checking status; trails the control byte by one register stage
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      CHECK_ENABLED <= 1'b0;
    end else begin
      CHECK_ENABLED <= check_on;
    end
  end

  // read mux; passwords read as zero, unmapped addresses read zero
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      MEM_RDATA <= 8'h00;
    end else if (in_window(MEM_ADDR, mcpg_pkg::ADDR_TIMESTAMP, mcpg_pkg::ADDR_MISSION_CNT)) begin
      MEM_RDATA <= pick_byte({16'h0, ts_ff}, MEM_ADDR - mcpg_pkg::ADDR_TIMESTAMP);
    end else if (in_window(MEM_ADDR, mcpg_pkg::ADDR_MISSION_CNT, mcpg_pkg::ADDR_LIFE_CNT)) begin
      MEM_RDATA <= pick_byte({40'h0, mission_cnt_ff}, MEM_ADDR - mcpg_pkg::ADDR_MISSION_CNT);
    end else if (in_window(MEM_ADDR, mcpg_pkg::ADDR_LIFE_CNT, mcpg_pkg::ADDR_VARIANT)) begin
      MEM_RDATA <= pick_byte({40'h0, life_cnt_ff}, MEM_ADDR - mcpg_pkg::ADDR_LIFE_CNT);
    end else if (in_window(MEM_ADDR, mcpg_pkg::ADDR_DELAY, mcpg_pkg::ADDR_TIMESTAMP)) begin
      MEM_RDATA <= pick_byte({40'h0, delay_ff}, MEM_ADDR - mcpg_pkg::ADDR_DELAY);
    end else if (MEM_ADDR == mcpg_pkg::ADDR_VARIANT) begin
      MEM_RDATA <= VARIANT;
    end else if (MEM_ADDR == mcpg_pkg::ADDR_PW_CTRL) begin
      MEM_RDATA <= pw_ctrl_ff;
    end else begin
      MEM_RDATA <= 8'h00;
    end
  end

endmodule

/* verif/mcpg_checker.sv */
// checker: port-level timing properties of the password gate, check enable and register reads
`timescale 1ns/1ps
module mcpg_checker #(
  parameter logic [7:0] VARIANT = mcpg_pkg::VARIANT_DEFAULT
) (
  input wire logic                SYS_CLK,
  input wire logic                SYS_RST,
  input wire logic [9:0]          MEM_ADDR,
  input wire logic                MEM_WR,
  input wire logic [7:0]          MEM_WDATA,
  input wire logic [7:0]          MEM_RDATA,
  input wire logic                CMD_VALID,
  input wire mcpg_pkg::mcpg_cmd_e CMD_CODE,
  input wire logic                CMD_END,
  input wire logic                CMD_GRANT,
  input wire logic                CMD_DENY,
  input wire logic                MISSION_ACTIVE,
  input wire logic                CHECK_ENABLED
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // free commands skip the password phase entirely
  sequence s_free_cmd;
    CMD_VALID && (CMD_CODE == mcpg_pkg::CMD_FORCED || CMD_CODE == mcpg_pkg::CMD_SCRATCH);
  endsequence
  sequence s_ctrl_wr;
    MEM_WR && MEM_ADDR == mcpg_pkg::ADDR_PW_CTRL;
  endsequence
  // check status trails the control byte by one stage, so its effects show two edges on
  free_cmd_grant_a: assert property (s_free_cmd |=> CMD_GRANT)
    else $error("free command not granted");
  end_answer_a: assert property (CMD_END |=> CMD_GRANT != CMD_DENY)
    else $error("no single answer after password");
  answer_pulse_a: assert property ((CMD_GRANT || CMD_DENY) |=> !CMD_GRANT && !CMD_DENY)
    else $error("answer stands too long");
  enable_match_a: assert property (s_ctrl_wr and !MISSION_ACTIVE && !CHECK_ENABLED
    |-> ##2 CHECK_ENABLED == ($past(MEM_WDATA, 2) == mcpg_pkg::PW_ENABLE_VALUE))
    else $error("check enable does not follow pattern");
  ctrl_locked_a: assert property (s_ctrl_wr and MISSION_ACTIVE |-> ##2 $stable(CHECK_ENABLED))
    else $error("control changed during mission");
  enable_hold_a: assert property (!MEM_WR |-> ##2 $stable(CHECK_ENABLED))
    else $error("check enable changed without write");
  reset_off_a: assert property (disable iff (1'b0) SYS_RST |=> !CHECK_ENABLED)
    else $error("checking on after reset");
  variant_read_a: assert property (MEM_ADDR == mcpg_pkg::ADDR_VARIANT |=> MEM_RDATA == VARIANT)
    else $error("variant code wrong");
  pw_hidden_a: assert property (MEM_ADDR >= mcpg_pkg::ADDR_READ_PW
    && MEM_ADDR <= mcpg_pkg::ADDR_FULL_PW + 10'h7 |=> MEM_RDATA == 8'h00)
    else $error("password readable");
endmodule

/* verif/mcpg_host.sv */
// partner model: bus master sending command codes and serial passwords
`timescale 1ns/1ps
module mcpg_host (
  input  wire logic           clk,
  output mcpg_pkg::mcpg_cmd_e cmd_code,
  output logic                cmd_valid,
  output logic                pw_bit_valid,
  output logic                pw_bit,
  output logic                cmd_end
);
  initial begin
    cmd_code = mcpg_pkg::CMD_NONE;
    cmd_valid = 1'b0;
    pw_bit_valid = 1'b0;
    pw_bit = 1'b0;
    cmd_end = 1'b0;
  end
  // n below zero sends a free command, which carries no password
  task automatic send(input mcpg_pkg::mcpg_cmd_e c, input logic [63:0] pw, input int n);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    @(negedge clk);
    cmd_valid = 1'b0;
    // password right after the code, bit 0 first
    for (int i = 0; i < n; i++) begin
      pw_bit_valid = 1'b1;
      pw_bit = pw[i];
      @(negedge clk);
    end
    pw_bit_valid = 1'b0;
    // released line flips so a held last value cannot pass as data
    pw_bit = ~pw_bit;
    if (n >= 0) begin
      cmd_end = 1'b1;
      @(negedge clk);
      cmd_end = 1'b0;
    end
  endtask
endmodule

/* verif/mcpg_top_tb.sv */
// testbench: drives gate and counters, judges registers and answers
`timescale 1ns/1ps
module mcpg_top_tb;
  logic clk, rst, wr, mact, sota, tick, mst, smp, first, atest;
  logic cv, pv, pb, ce, gr, dn, dexp, aclr, chk;
  logic [9:0] addr;
  logic [7:0] wd, rd, v8;
  logic [23:0] life, v24;
  logic [63:0] fpw, rpw;
  mcpg_pkg::mcpg_cmd_e cc;
  mcpg_pkg::mcpg_time_s rtc;
  int fail_count, n_tests;
  mcpg_top dut (.SYS_CLK(clk), .SYS_RST(rst), .MEM_ADDR(addr), .MEM_WR(wr),
    .MEM_WDATA(wd), .MEM_RDATA(rd), .CMD_VALID(cv), .CMD_CODE(cc), .PW_BIT_VALID(pv),
    .PW_BIT(pb), .CMD_END(ce), .CMD_GRANT(gr), .CMD_DENY(dn), .MISSION_ACTIVE(mact),
    .START_ON_TEMP_ALARM(sota), .MINUTE_TICK(tick), .MISSION_START(mst),
    .SAMPLE_TAKEN(smp), .FIRST_SAMPLE(first), .ALARM_TEST(atest), .RTC_TIME(rtc),
    .DELAY_EXPIRED(dexp), .ALARM_FLAGS_CLR(aclr), .CHECK_ENABLED(chk));
  mcpg_host host (.clk(clk), .cmd_code(cc), .cmd_valid(cv), .pw_bit_valid(pv),
    .pw_bit(pb), .cmd_end(ce));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // bus reads: data is registered, so it shows one cycle after the address
  task automatic rd8(input logic [9:0] a, output logic [7:0] v);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    v = rd;
  endtask
  task automatic rd24(input logic [9:0] a, output logic [23:0] v);
    for (int i = 0; i < 3; i++) rd8(a + 10'(i), v[8*i+:8]);
  endtask
  task automatic wr8(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // one-cycle event pulse: 0 sample, 1 alarm test, 2 minute, 3 mission start
  task automatic ev(input int k);
    @(negedge clk);
    {mst, tick, atest, smp} = 4'(1 << k);
    @(negedge clk);
    {mst, tick, atest, smp} = 4'h0;
  endtask
  // issue a command and judge grant versus deny under a bounded wait
  task automatic cmd(input mcpg_pkg::mcpg_cmd_e c, input logic [63:0] p, input int n,
                     input logic g);
    host.send(c, p, n);
    for (int k = 0; k < 4 && gr !== 1'b1 && dn !== 1'b1; k++) @(negedge clk);
    if (gr !== 1'b1 && dn !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    cmp({gr, dn}, {g, ~g}, "answer");
    @(negedge clk);
  endtask
  task automatic t_free;
    rd8(mcpg_pkg::ADDR_VARIANT, v8);
    cmp(v8, mcpg_pkg::VARIANT_DEFAULT, "variant");
    rd8(mcpg_pkg::ADDR_PW_CTRL, v8);
    cmp({v8, chk}, {mcpg_pkg::PW_CTRL_RESET, 1'b0}, "ctrl reset");
    rd24(mcpg_pkg::ADDR_LIFE_CNT, life);
    cmd(mcpg_pkg::CMD_FORCED, 64'h0, -1, 1'b1);
    cmd(mcpg_pkg::CMD_SCRATCH, 64'h0, -1, 1'b1);
    rd24(mcpg_pkg::ADDR_LIFE_CNT, v24);
    cmp(v24, life + 24'h1, "forced count");
    for (int c = 1; c < 6; c++) cmd(mcpg_pkg::mcpg_cmd_e'(c), fpw, 64, 1'b1);
    cmd(mcpg_pkg::CMD_READ_CRC, fpw, 63, 1'b0);
  endtask
  task automatic t_mission;
    mact = 1'b1;
    first = 1'b1;
    ev(0);
    first = 1'b0;
    ev(0);
    ev(1);
    wr8(mcpg_pkg::ADDR_PW_CTRL, mcpg_pkg::PW_ENABLE_VALUE);
    @(negedge clk); // status trails the control byte by one cycle
    cmp(chk, 1'b0, "ctrl locked");
    rd24(mcpg_pkg::ADDR_MISSION_CNT, v24);
    cmp(v24, 24'h2, "mission count");
    rd24(mcpg_pkg::ADDR_LIFE_CNT, v24);
    cmp(v24, life + 24'h4, "lifetime count");
    for (int i = 0; i < 6; i++) begin
      rd8(mcpg_pkg::ADDR_TIMESTAMP + 10'(i), v8);
      cmp(v8, rtc[8*i+:8], "timestamp");
    end
    mact = 1'b0;
  endtask
  task automatic t_gate;
    for (int i = 0; i < 8; i++) begin
      wr8(mcpg_pkg::ADDR_FULL_PW + 10'(i), fpw[8*i+:8]);
      wr8(mcpg_pkg::ADDR_READ_PW + 10'(i), rpw[8*i+:8]);
    end
    wr8(mcpg_pkg::ADDR_PW_CTRL, mcpg_pkg::PW_ENABLE_VALUE);
    @(negedge clk); // status trails the control byte by one cycle
    cmp(chk, 1'b1, "check on");
    cmd(mcpg_pkg::CMD_CLEAR_MEM, rpw, 64, 1'b0);
    cmp(aclr, 1'b0, "no flag clear");
    rd24(mcpg_pkg::ADDR_MISSION_CNT, v24);
    cmp(v24, 24'h2, "denied clear");
    cmd(mcpg_pkg::CMD_READ_CRC, rpw, 64, 1'b1);
    cmd(mcpg_pkg::CMD_CLEAR_MEM, fpw, 64, 1'b1);
    cmp(aclr, 1'b1, "flag clear");
    rd24(mcpg_pkg::ADDR_MISSION_CNT, v24);
    cmp(v24, 24'h0, "cleared count");
    rd8(mcpg_pkg::ADDR_TIMESTAMP, v8);
    cmp(v8, 8'h00, "cleared stamp");
    rd24(mcpg_pkg::ADDR_LIFE_CNT, v24);
    cmp(v24, life + 24'h4, "lifetime kept");
    mact = 1'b1;
    sota = 1'b1;
    first = 1'b1;
    ev(0);
    rd24(mcpg_pkg::ADDR_MISSION_CNT, v24);
    cmp(v24, 24'h0, "alarm start first");
    {mact, sota, first} = 3'h0;
  endtask
  task automatic t_delay;
    // staggered start of a chained logger
    wr8(mcpg_pkg::ADDR_DELAY, 8'h02);
    wr8(mcpg_pkg::ADDR_DELAY + 10'h1, 8'h00);
    wr8(mcpg_pkg::ADDR_DELAY + 10'h2, 8'h00);
    mact = 1'b1; // the countdown runs only inside a mission
    ev(3);
    ev(2);
    cmp(dexp, 1'b0, "delay running");
    ev(2);
    for (int k = 0; k < 3 && dexp !== 1'b1; k++) @(negedge clk);
    cmp(dexp, 1'b1, "delay expired");
    mact = 1'b0;
  endtask
  initial begin
    {wr, mact, sota, tick, mst, smp, first, atest} = 8'h00;
    addr = 10'h000;
    wd = 8'h00;
    rtc = 48'h250615134530;
    fpw = 64'h0123456789abcdef;
    rpw = 64'hfedcba9876543210;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_free();
    t_mission();
    t_gate();
    t_delay();
    stop_test();
  end
endmodule
bind mcpg_top mcpg_checker #(.VARIANT(VARIANT)) u_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .MEM_ADDR(MEM_ADDR), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
  .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_END(CMD_END), .CMD_GRANT(CMD_GRANT),
  .CMD_DENY(CMD_DENY), .MISSION_ACTIVE(MISSION_ACTIVE), .CHECK_ENABLED(CHECK_ENABLED));
